// File: design/cgo_regs.sv
// Gain and offset correction register bank for channels 5 to 7
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Gain code bits 15-11, N times 0.2 dB
// - Offset is 10-bit signed, 14-bit sample LSB
// - Offset applied only while offset enable set
// - Channel 6 at 1Bh, copy at 1Ch
// - Channel 7 at 1Dh, copy at 1Eh
// - Correction and control fields read/write, status read-only, all reset to zero
module cgo_regs
    import cgo_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [CGO_ADDR_W-1:0] addr,
    input wire logic [CGO_DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [CGO_DATA_W-1:0] rdata_q,
    output cgo_corr_t [CGO_NCH-1:0] chan_corr_q,
    output logic [CGO_NCH-1:0] mismatch_q,
    output logic global_gain_enable_q,
    output logic global_offset_enable_q
);

    // ==================================================================
    // Storage
    logic [CGO_DATA_W-1:0] go_q [CGO_NCH];
    logic [CGO_DATA_W-1:0] cp_q [CGO_NCH];
    cgo_cfg_t cfg_q;
    logic [CGO_DATA_W-1:0] rdata_d;

    // ==================================================================
    // Correction registers, all bits stored as written
    genvar gi;
    generate
        for (gi = 0; gi < CGO_NCH; gi++) begin : g_chan
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    go_q[gi] <= CGO_REG_RESET;
                end else if (wr_stb && addr == CGO_ADDR_GO[gi]) begin
                    go_q[gi] <= wdata;
                end
            end

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    cp_q[gi] <= CGO_REG_RESET;
                end else if (wr_stb && addr == CGO_ADDR_CP[gi]) begin
                    cp_q[gi] <= wdata;
                end
            end

            cgo_chan_apply u_apply (
                .mclk(mclk),
                .arst_n(arst_n),
                .go_reg(go_q[gi]),
                .cp_reg(cp_q[gi]),
                .cfg(cfg_q),
                .corr_q(chan_corr_q[gi]),
                .mismatch_q(mismatch_q[gi])
            );
        end
    endgenerate

    // ==================================================================
    // Global enables
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '0;
        end else if (wr_stb && addr == CGO_ADDR_CTRL) begin
            cfg_q.gain_en <= wdata[CGO_CTRL_GAIN_BIT];
            cfg_q.offset_en <= wdata[CGO_CTRL_OFS_BIT];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            global_gain_enable_q <= 1'b0;
            global_offset_enable_q <= 1'b0;
        end else begin
            global_gain_enable_q <= cfg_q.gain_en;
            global_offset_enable_q <= cfg_q.offset_en;
        end
    end

    // ==================================================================
    // Read path
    always_comb begin
        rdata_d = CGO_RD_IDLE;
        for (int i = 0; i < CGO_NCH; i++) begin
            if (addr == CGO_ADDR_GO[i]) begin
                rdata_d = go_q[i];
            end
            if (addr == CGO_ADDR_CP[i]) begin
                rdata_d = cp_q[i];
            end
        end
        if (addr == CGO_ADDR_CTRL) begin
            rdata_d[CGO_CTRL_GAIN_BIT] = cfg_q.gain_en;
            rdata_d[CGO_CTRL_OFS_BIT] = cfg_q.offset_en;
        end
        if (addr == CGO_ADDR_STAT) begin
            rdata_d[CGO_NCH-1:0] = mismatch_q;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= CGO_RD_IDLE;
        end else if (rd_stb) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= CGO_RD_IDLE;
        end
    end

    // ==================================================================
    // Assertions
    property p_sixth_channel_gain_code;
        @(posedge mclk) disable iff (!arst_n)
        1 |=> chan_corr_q[1].gain_cdb == ($past(cfg_q.gain_en) ?
            CGO_GAIN_CDB_W'($past(go_q[1][CGO_GAIN_MSB:CGO_GAIN_LSB])) * CGO_GAIN_STEP_CDB
            : '0);
    endproperty
    a_sixth_channel_gain_code: assert property (p_sixth_channel_gain_code)
        else $error("channel 6 applied gain wrong");

    property p_gain_max;
        @(posedge mclk) disable iff (!arst_n)
        (cfg_q.gain_en && go_q[2][CGO_GAIN_MSB:CGO_GAIN_LSB] == 5'h1f) ##1 cfg_q.gain_en
        |-> chan_corr_q[2].gain_cdb == 10'h26c;
    endproperty
    a_gain_max: assert property (p_gain_max)
        else $error("full scale gain is not 6.2 dB");

    property p_offset_sext;
        @(posedge mclk) disable iff (!arst_n)
        cfg_q.offset_en |=> chan_corr_q[0].offset_lsb14 ==
            {{4{$past(go_q[0][CGO_OFS_MSB])}}, $past(go_q[0][CGO_OFS_MSB:CGO_OFS_LSB])};
    endproperty
    a_offset_sext: assert property (p_offset_sext)
        else $error("offset not sign extended to sample width");

    property p_offset_off;
        @(posedge mclk) disable iff (!arst_n)
        !cfg_q.offset_en |=> chan_corr_q[0].offset_lsb14 == '0
            && chan_corr_q[1].offset_lsb14 == '0 && chan_corr_q[2].offset_lsb14 == '0;
    endproperty
    a_offset_off: assert property (p_offset_off)
        else $error("offset applied while disabled");

    property p_wr_ch6;
        @(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == 8'h1b) |=> go_q[1] == $past(wdata) && cp_q[1] == $past(cp_q[1]);
    endproperty
    a_wr_ch6: assert property (p_wr_ch6)
        else $error("channel 6 gain/offset register not at 1Bh");

    property p_rd_ch6;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == 8'h1b) |=> rdata_q == $past(go_q[1]);
    endproperty
    a_rd_ch6: assert property (p_rd_ch6)
        else $error("channel 6 gain/offset not read at 1Bh");

    property p_wr_ch6_copy;
        @(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == 8'h1c) |=> cp_q[1] == $past(wdata) && go_q[1] == $past(go_q[1]);
    endproperty
    a_wr_ch6_copy: assert property (p_wr_ch6_copy)
        else $error("channel 6 copy not written at 1Ch");

    property p_rd_ch6_copy;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == 8'h1c) |=> rdata_q == $past(cp_q[1]);
    endproperty
    a_rd_ch6_copy: assert property (p_rd_ch6_copy)
        else $error("channel 6 copy not read at 1Ch");

    property p_wr_ch7_copy;
        @(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == 8'h1e) |=> cp_q[2] == $past(wdata) && go_q[2] == $past(go_q[2]);
    endproperty
    a_wr_ch7_copy: assert property (p_wr_ch7_copy)
        else $error("channel 7 copy not at 1Eh");

    property p_rd_ch7;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == 8'h1d) |=> rdata_q == $past(go_q[2]);
    endproperty
    a_rd_ch7: assert property (p_rd_ch7)
        else $error("channel 7 gain/offset not read at 1Dh");

    property p_reset_zero;
        @(posedge mclk)
        !arst_n |-> go_q[0] == '0 && go_q[1] == '0 && go_q[2] == '0
            && cp_q[0] == '0 && cp_q[1] == '0 && cp_q[2] == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("correction register not zero in reset");

    property p_rd_idle;
        @(posedge mclk) disable iff (!arst_n)
        !rd_stb |=> rdata_q == CGO_RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data present without a read");

    property p_wr_ch7;
        @(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == 8'h1d) |=> go_q[2] == $past(wdata) && cp_q[2] == $past(cp_q[2]);
    endproperty
    a_wr_ch7: assert property (p_wr_ch7)
        else $error("channel 7 gain/offset not written at 1Dh");

    property p_rd_ch7_copy;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == 8'h1e) |=> rdata_q == $past(cp_q[2]);
    endproperty
    a_rd_ch7_copy: assert property (p_rd_ch7_copy)
        else $error("channel 7 copy not read at 1Eh");

    property p_hold_regs;
        @(posedge mclk) disable iff (!arst_n)
        !wr_stb |=> go_q[0] == $past(go_q[0]) && go_q[1] == $past(go_q[1])
            && go_q[2] == $past(go_q[2]) && cp_q[0] == $past(cp_q[0])
            && cp_q[1] == $past(cp_q[1]) && cp_q[2] == $past(cp_q[2]);
    endproperty
    a_hold_regs: assert property (p_hold_regs)
        else $error("correction register changed without a write");

    property p_gain_off;
        @(posedge mclk) disable iff (!arst_n)
        !cfg_q.gain_en |=> chan_corr_q[0].gain_cdb == '0
            && chan_corr_q[1].gain_cdb == '0 && chan_corr_q[2].gain_cdb == '0;
    endproperty
    a_gain_off: assert property (p_gain_off)
        else $error("gain applied while disabled");

    property p_seventh_channel_offset_value;
        @(posedge mclk) disable iff (!arst_n)
        cfg_q.offset_en |=> chan_corr_q[2].offset_lsb14 ==
            {{4{$past(go_q[2][CGO_OFS_MSB])}}, $past(go_q[2][CGO_OFS_MSB:CGO_OFS_LSB])};
    endproperty
    a_seventh_channel_offset_value: assert property (p_seventh_channel_offset_value)
        else $error("channel 7 offset not sign extended");

    property p_enable_copy;
        @(posedge mclk) disable iff (!arst_n)
        1 |=> global_gain_enable_q == $past(cfg_q.gain_en)
            && global_offset_enable_q == $past(cfg_q.offset_en);
    endproperty
    a_enable_copy: assert property (p_enable_copy)
        else $error("enable outputs do not follow control register");

    property p_ctrl_write;
        @(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == CGO_ADDR_CTRL) |=> cfg_q.gain_en == $past(wdata[CGO_CTRL_GAIN_BIT])
            && cfg_q.offset_en == $past(wdata[CGO_CTRL_OFS_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control register write not taken");

    property p_unmapped_rd;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == 8'h1f) |=> rdata_q == CGO_RD_IDLE;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd)
        else $error("unmapped read returned data");

    property p_stat_rd;
        @(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == CGO_ADDR_STAT) |=> rdata_q == {13'h0000, $past(mismatch_q)};
    endproperty
    a_stat_rd: assert property (p_stat_rd)
        else $error("status read does not show copy mismatch");

    c_gain_applied: cover property (@(posedge mclk) disable iff (!arst_n)
        cfg_q.gain_en ##1 chan_corr_q[1].gain_cdb != '0);
    c_mismatch: cover property (@(posedge mclk) disable iff (!arst_n)
        $rose(mismatch_q[2]));
    c_wr_then_rd: cover property (@(posedge mclk) disable iff (!arst_n)
        (wr_stb && addr == 8'h1c) ##1 (rd_stb && addr == 8'h1c));
    c_neg_offset: cover property (@(posedge mclk) disable iff (!arst_n)
        chan_corr_q[0].offset_lsb14[CGO_SAMPLE_W-1]);
    c_stat_read: cover property (@(posedge mclk) disable iff (!arst_n)
        (rd_stb && addr == CGO_ADDR_STAT) ##1 rdata_q != '0);

endmodule : cgo_regs

`default_nettype wire

// File: design/cgo_pkg.sv
// Package: register map, field layout and carrier types of the gain/offset correction bank
package cgo_pkg;

    // ==================================================================
    // Sizes
    localparam int CGO_NCH = 3;
    localparam int CGO_ADDR_W = 8;
    localparam int CGO_DATA_W = 16;

    // ==================================================================
    // Register offsets, index 0 is channel 5
    localparam logic [CGO_ADDR_W-1:0] CGO_ADDR_GO [CGO_NCH] = '{8'h19, 8'h1b, 8'h1d};
    localparam logic [CGO_ADDR_W-1:0] CGO_ADDR_CP [CGO_NCH] = '{8'h1a, 8'h1c, 8'h1e};
    localparam logic [CGO_ADDR_W-1:0] CGO_ADDR_CTRL = 8'hf0;
    localparam logic [CGO_ADDR_W-1:0] CGO_ADDR_STAT = 8'hf1;

    // ==================================================================
    // Field layout
    localparam int CGO_GAIN_MSB = 15;
    localparam int CGO_GAIN_LSB = 11;
    localparam int CGO_GAIN_W = 5;
    localparam int CGO_OFS_MSB = 9;
    localparam int CGO_OFS_LSB = 0;
    localparam int CGO_OFS_W = 10;
    localparam int CGO_SAMPLE_W = 14;
    localparam int CGO_GAIN_CDB_W = 10;
    localparam int CGO_CTRL_GAIN_BIT = 0;
    localparam int CGO_CTRL_OFS_BIT = 1;

    // ==================================================================
    // Values
    localparam logic [CGO_DATA_W-1:0] CGO_REG_RESET = 16'h0000;
    localparam logic [CGO_DATA_W-1:0] CGO_RD_IDLE = 16'h0000;
    // Gain step in hundredths of a dB (0.2 dB)
    localparam logic [CGO_GAIN_CDB_W-1:0] CGO_GAIN_STEP_CDB = 10'h014;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic [CGO_GAIN_CDB_W-1:0] gain_cdb;
        logic [CGO_SAMPLE_W-1:0] offset_lsb14;
    } cgo_corr_t;

    typedef struct packed {
        logic offset_en;
        logic gain_en;
    } cgo_cfg_t;

endpackage : cgo_pkg

// File: design/cgo_chan_apply.sv
// Per-channel stage that turns the stored fields into the applied correction
`timescale 1ns/100ps
`default_nettype none

module cgo_chan_apply
    import cgo_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [CGO_DATA_W-1:0] go_reg,
    input wire logic [CGO_DATA_W-1:0] cp_reg,
    input wire cgo_cfg_t cfg,
    output cgo_corr_t corr_q,
    output logic mismatch_q
);

    logic [CGO_GAIN_W-1:0] gain_code;
    logic [CGO_OFS_W-1:0] ofs_code;
    cgo_corr_t corr_d;

    assign gain_code = go_reg[CGO_GAIN_MSB:CGO_GAIN_LSB];
    assign ofs_code = go_reg[CGO_OFS_MSB:CGO_OFS_LSB];

    // ==================================================================
    // Applied values
    always_comb begin
        corr_d = '0;
        if (cfg.gain_en) begin
            corr_d.gain_cdb = CGO_GAIN_CDB_W'(gain_code) * CGO_GAIN_STEP_CDB;
        end
        if (cfg.offset_en) begin
            corr_d.offset_lsb14 = {{(CGO_SAMPLE_W-CGO_OFS_W){ofs_code[CGO_OFS_W-1]}},
                                   ofs_code};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            corr_q <= '0;
        end else begin
            corr_q <= corr_d;
        end
    end

    // ==================================================================
    // Copy check
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= (cp_reg[CGO_OFS_MSB:CGO_OFS_LSB] != ofs_code);
        end
    end

    // ==================================================================
    // Checks
    property p_mismatch_flag;
        @(posedge mclk) disable iff (!arst_n)
        1 |=> mismatch_q == ($past(cp_reg[CGO_OFS_MSB:CGO_OFS_LSB]) != $past(ofs_code));
    endproperty
    a_mismatch_flag: assert property (p_mismatch_flag)
        else $error("copy mismatch flag wrong");

endmodule : cgo_chan_apply

`default_nettype wire

// File: verification/cgo_regs_test.sv
// Self-checking bench of the gain and offset correction register bank
`timescale 1ns/100ps
`default_nettype none

module cgo_regs_test
    import cgo_pkg::*;
;
    // ==========================================
    // Signals and model state
    logic mclk = 1'b0;
    logic arst_n = 1'b1;
    logic [CGO_ADDR_W-1:0] addr = '0;
    logic [CGO_DATA_W-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [CGO_DATA_W-1:0] rdata_q;
    cgo_corr_t [CGO_NCH-1:0] chan_corr_q;
    logic [CGO_NCH-1:0] mismatch_q;
    logic global_gain_enable_q;
    logic global_offset_enable_q;
    logic rd_pend = 1'b0;
    logic [CGO_DATA_W-1:0] exp_q [$];
    logic [CGO_DATA_W-1:0] go [CGO_NCH];
    logic [CGO_DATA_W-1:0] cp [CGO_NCH];
    logic [9:0] ofs;
    logic [1:0] en;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    integer seed = 32'hfce26a70;

    always #4 mclk = ~mclk;

    cgo_regs i_dut (
        .mclk(mclk),
        .arst_n(arst_n),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata_q(rdata_q),
        .chan_corr_q(chan_corr_q),
        .mismatch_q(mismatch_q),
        .global_gain_enable_q(global_gain_enable_q),
        .global_offset_enable_q(global_offset_enable_q)
    );

    // ==========================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [CGO_ADDR_W-1:0] a, input logic [CGO_DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [CGO_ADDR_W-1:0] a, input logic [CGO_DATA_W-1:0] e);
        exp_q.push_back(e);
        addr <= a;
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge mclk);
    endtask : rd

    task automatic idle(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic do_reset();
        arst_n <= 1'b0;
        idle(20);
        arst_n <= 1'b1;
        for (int i = 0; i < CGO_NCH; i++) begin
            go[i] = '0;
            cp[i] = '0;
        end
        @(posedge mclk);
    endtask : do_reset

    task automatic chk_corr(input logic [1:0] e);
        logic [CGO_NCH-1:0] mm;
        @(negedge mclk);
        for (int i = 0; i < CGO_NCH; i++) begin
            mm[i] = go[i][9:0] != cp[i][9:0];
            check("gain", chan_corr_q[i].gain_cdb,
                  e[0] ? {5'h00, go[i][15:11]} * 10'h014 : 10'h000);
            check("offset", chan_corr_q[i].offset_lsb14,
                  e[1] ? {{4{go[i][9]}}, go[i][9:0]} : 14'h0000);
        end
        check("mismatch", mismatch_q, mm);
        check("gain enable", global_gain_enable_q, e[0]);
        check("offset enable", global_offset_enable_q, e[1]);
        @(posedge mclk);
    endtask : chk_corr

    task automatic read_all();
        for (int i = 0; i < CGO_NCH; i++) begin
            rd(CGO_ADDR_GO[i], go[i]);
            rd(CGO_ADDR_CP[i], cp[i]);
        end
        idle(2);
    endtask : read_all

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // ==========================================
    // Read data watcher
    always @(posedge mclk) begin
        if (!arst_n) begin
            rd_pend <= 1'b0;
        end else begin
            if (rd_pend) begin
                check("rdata", rdata_q, exp_q.pop_front());
            end else begin
                check("rdata idle", rdata_q, 16'h0000);
            end
            rd_pend <= rd_stb;
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            $display("timeout");
            n_fail++;
            final_report();
        end
    end

    // ==========================================
    // Sequence
    initial begin
        do_reset();
        read_all();
        chk_corr(2'b00);
        $display("test reset_values done");
        repeat (4) begin
            for (int i = 0; i < CGO_NCH; i++) begin
                go[i] = 16'($random(seed));
                cp[i] = 16'($random(seed));
                wr(CGO_ADDR_GO[i], go[i]);
                wr(CGO_ADDR_CP[i], cp[i]);
            end
            read_all();
        end
        wr(8'h1f, 16'hffff);
        rd(8'h1f, 16'h0000);
        rd(8'h18, 16'h0000);
        idle(2);
        chk_corr(2'b00);
        $display("test read_write done");
        for (int k = 0; k < 32; k++) begin
            ofs = (k == 0) ? 10'h200 : (k == 31) ? 10'h1fe : 10'($random(seed));
            en = 2'(k);
            wr(CGO_ADDR_CTRL, {14'h0000, en});
            for (int i = 0; i < CGO_NCH; i++) begin
                go[i] = {5'(k), 1'b0, ofs + 10'(i)};
                cp[i] = {6'h00, go[i][9:0]};
                wr(CGO_ADDR_GO[i], go[i]);
                wr(CGO_ADDR_CP[i], cp[i]);
            end
            idle(2);
            chk_corr(en);
        end
        $display("test gain_offset done");
        cp[1] = cp[1] ^ 16'h0001;
        wr(CGO_ADDR_CP[1], cp[1]);
        rd(CGO_ADDR_CP[1], cp[1]);
        wr(CGO_ADDR_STAT, 16'hffff);
        rd(CGO_ADDR_CTRL, 16'h0003);
        idle(1);
        rd(CGO_ADDR_STAT, 16'h0002);
        idle(2);
        chk_corr(2'b11);
        $display("test mismatch done");
        do_reset();
        read_all();
        chk_corr(2'b00);
        $display("test second_reset done");
        final_report();
    end
endmodule : cgo_regs_test

`default_nettype wire
